// ===== bench/ffs_bridge_model.sv
// Far side: speed check and brake strap
`timescale 1ns/100ps
module ffs_bridge_model (
    // Clock
    input wire logic clock_i,
    // From the supervisor; strap select from the bench
    input wire ffs_pkg::ffs_mode_type mode_i,
    input wire logic fault_out_n_i,
    input wire logic brake_wired_i,
    // Back to the supervisor
    output logic windmill_done_o = 1'b0,
    output logic brake_in_n_o
);
    logic [2:0] spin = 3'h0;
    // Speed check takes a few cycles
    always_ff @(posedge clock_i) begin
        spin <= mode_i == ffs_pkg::MODE_WINDMILL ? spin + 3'h1 : 3'h0;
        windmill_done_o <= spin == 3'h4;
    end
    // Strap fitted: fault pin is the brake; else pulled high
    assign brake_in_n_o = brake_wired_i ? fault_out_n_i : 1'b1;
endmodule : ffs_bridge_model

// ===== bench/ffs_top_monitor.sv
// Port checker for the fault supervisor
`timescale 1ns/100ps
module ffs_top_monitor (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Settings, monitors and command
    input wire logic [1:0] undervoltage_threshold_sel_i,
    input wire logic undervoltage_mask_i,
    input wire logic overtemp_mask_i,
    input wire logic [7:0] command_on_threshold_i,
    input wire logic [9:0] supply_dv_i,
    input wire logic [7:0] junction_temp_i,
    input wire logic [7:0] command_i,
    input wire logic user_mode_i,
    input wire logic logic_supply_ok_i,
    // Outputs watched
    input wire logic fault_out_n_o,
    input wire logic bridge_enable_o,
    input wire logic low_side_brake_o,
    input wire ffs_pkg::ffs_mode_type mode_o,
    input wire logic [6:0] fault_status_o,
    input wire logic nvm_program_allow_o
);
    logic [1:0] up;
    logic [9:0] th;
    logic uvl;
    logic otl;
    // Faults judged once settings are in
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end
    // Code 3 is the lowest level
    assign th = undervoltage_threshold_sel_i == 2'h0 ? ffs_pkg::UV_TH_32V :
        undervoltage_threshold_sel_i == 2'h1 ? ffs_pkg::UV_TH_25V : ffs_pkg::UV_TH_7V;
    assign uvl = up == 2'h3 && !undervoltage_mask_i && supply_dv_i < th;
    assign otl = up == 2'h3 && !overtemp_mask_i && junction_temp_i > ffs_pkg::TSD_TH;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Cause held two samples; answer due next
    sequence s_uv; uvl ##1 uvl; endsequence
    sequence s_ot; otl ##1 otl; endsequence
    sequence s_idle;
        mode_o == ffs_pkg::MODE_STANDBY && command_i <= command_on_threshold_i;
    endsequence
    a_uv_fail_entry: assert property (s_uv |=> !fault_out_n_o && fault_status_o[0]
        && mode_o == ffs_pkg::MODE_FAIL) else $error("uv missed");
    a_ot_fail_entry: assert property (s_ot |=> !fault_out_n_o && fault_status_o[1]
        && mode_o == ffs_pkg::MODE_FAIL) else $error("ot missed");
    a_uv_mask_hold: assert property (undervoltage_mask_i |-> !fault_status_o[0])
        else $error("masked uv flagged");
    a_flag_drives_pin: assert property (|fault_status_o[5:0] |-> !fault_out_n_o)
        else $error("flag without pin");
    a_fail_bridge_off: assert property (mode_o == ffs_pkg::MODE_FAIL |-> !bridge_enable_o)
        else $error("bridge on in fail mode");
    a_brake_short_only: assert property (low_side_brake_o |-> !(|(fault_status_o & 7'h37)))
        else $error("bad brake");
    a_nvm_window: assert property ($rose(nvm_program_allow_o)
        |-> $past(user_mode_i) && $past(logic_supply_ok_i)) else $error("nvm window opened");
    a_standby_wait: assert property (s_idle ##1 s_idle |=> mode_o != ffs_pkg::MODE_WINDMILL)
        else $error("left standby early");
endmodule : ffs_top_monitor
bind ffs_top ffs_top_monitor i_mon (.*);

// ===== bench/ffs_top_tb_top.sv
// Self-checking bench for the supervisor
`timescale 1ns/100ps
module ffs_top_tb_top;
    // Inputs
    logic clock_i = 1'b0, rst_i = 1'b1, undervoltage_mask_i = 1'b0, user_mode_i = 1'b1;
    logic supply_overvoltage_i = 1'b0, short_detect_i = 1'b0, stall_detect_i = 1'b0;
    logic overtemp_mask_i = 1'b0, overvoltage_fault_en_i = 1'b1, short_fault_en_i = 1'b1;
    logic no_motor_detect_en_i = 1'b1, logic_supply_ok_i = 1'b1, no_motor_detect_i = 1'b0;
    logic [1:0] undervoltage_threshold_sel_i = 2'h2, stall_detect_select_i = 2'h1;
    logic [9:0] supply_dv_i = 10'h0f0, nominal_supply_setting_i = 10'h0f0;
    logic [7:0] junction_temp_i = 8'h19, command_i = 8'h00, command_on_threshold_i = 8'h64;
    logic [7:0] command_off_threshold_i = 8'h20;
    logic [15:0] stator_inductance_setting_i = 16'h0123, stator_resistance_setting_i = 16'h0456;
    logic [15:0] observer_freq_gain_i = 16'h0055, observer_angle_gain_i = 16'h0066;
    logic [4:0] inductance_frac_length_i = 5'h1d, resistance_frac_length_i = 5'h05;
    logic [3:0] frequency_resolution_setting_i = 4'h4;
    logic [2:0][13:0] phase_voltage_i = {3{14'h0800}};
    logic windmill_done_i, brake_in_n_i, wired = 1'b0;
    // Outputs
    logic fault_out_n_o, bridge_enable_o, low_side_brake_o, nvm_program_allow_o, duty_valid_o;
    ffs_pkg::ffs_mode_type mode_o;
    logic [6:0] fault_status_o;
    logic [2:0][12:0] duty_o;
    logic [15:0] d_ref_o, inductance_o, resistance_o;
    logic [3:0][15:0] loop_gains_o;
    logic [1:0][15:0] observer_gains_o;
    logic signed [6:0] inductance_exp_o, resistance_exp_o;
    logic [18:0] freq_lsb_div_o;
    // Supply steps and duty at half voltage
    logic [9:0] sup[5] = '{10'h078, 10'h0f0, 10'h100, 10'h140, 10'h180};
    logic [12:0] dex[5] = '{13'h1000, 13'h0800, 13'h0780, 13'h0600, 13'h0500};
    logic [12:0] exp_q[$];
    logic [12:0] d;
    int err_total = 0, num_checks = 0;
    always #4 clock_i = ~clock_i;
    ffs_top #(.RETRY_CYCLES(20)) i_dut (.d_axis_current_ref_i(16'h0007),
        .d_loop_prop_gain_i(16'h0011), .d_loop_int_gain_i(16'h0022),
        .q_loop_prop_gain_i(16'h0033), .q_loop_int_gain_i(16'h0044), .*);
    ffs_bridge_model i_far (.clock_i(clock_i), .mode_i(mode_o), .fault_out_n_i(fault_out_n_o),
        .brake_wired_i(wired), .windmill_done_o(windmill_done_i), .brake_in_n_o(brake_in_n_i));
    // Four-state compare, so an unknown never matches
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
    endtask : wt
    // Pin, bridge, mode, flags
    task automatic st(input logic [10:0] e);
        chk({fault_out_n_o, bridge_enable_o, mode_o, fault_status_o}, e);
    endtask : st
    task automatic report_and_stop();
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    // Each valid pulse settles the oldest note
    always @(negedge clock_i) begin
        if (duty_valid_o === 1'b1 && exp_q.size() > 0) begin
            d = exp_q.pop_front();
            chk(duty_o, {3{d}});
        end
    end
    // Watchdog
    initial begin
        wt(20000);
        err_total++;
        report_and_stop();
    end
    initial begin
        int j;
        void'($urandom(32'h1f3b5080));
        wt(2);
        rst_i <= 1'b0;
        wt(4);
        chk({inductance_o, resistance_o, inductance_exp_o, resistance_exp_o, freq_lsb_div_o},
            {16'h0123, 16'h0456, 7'h12, 7'h10, 19'h00090});
        chk({d_ref_o, loop_gains_o, observer_gains_o}, 112'h0007_0044_0033_0022_0011_0066_0055);
        // At the on level: no start
        command_i <= 8'h64;
        wt(6);
        st(11'h400);
        command_i <= 8'hc8;
        wt(20);
        st(11'h780);
        // Random supply sweep
        repeat (8) begin
            j = $urandom % 5;
            supply_dv_i <= sup[j];
            wt(170);
            exp_q.push_back(dex[j]);
            wt(90);
            chk(exp_q.size(), 0);
        end
        // Sag below 7 V; hysteresis holds
        supply_dv_i <= 10'h045;
        wt(4);
        st(11'h101);
        chk({nvm_program_allow_o, duty_o}, {1'b1, 39'h0});
        user_mode_i <= 1'b0;
        supply_dv_i <= 10'h04f;
        junction_temp_i <= 8'haa;
        wt(4);
        st(11'h103);
        chk(nvm_program_allow_o, 1'b0);
        command_i <= 8'h00;
        supply_dv_i <= 10'h051;
        wt(4);
        st(11'h102);
        junction_temp_i <= 8'h92;
        wt(4);
        st(11'h102);
        junction_temp_i <= 8'h90;
        wt(4);
        st(11'h400);
        // Strapped: overvoltage no brake, short brakes
        wired <= 1'b1;
        command_i <= 8'h40;
        supply_overvoltage_i <= 1'b1;
        wt(4);
        st(11'h104);
        chk(low_side_brake_o, 1'b0);
        supply_overvoltage_i <= 1'b0;
        short_detect_i <= 1'b1;
        wt(4);
        short_detect_i <= 1'b0;
        wt(4);
        st(11'h108);
        chk(low_side_brake_o, 1'b1);
        command_i <= 8'h00;
        wt(4);
        st(11'h400);
        // Stall and no-motor clear on retry
        command_i <= 8'hc8;
        wt(20);
        stall_detect_i <= 1'b1;
        no_motor_detect_i <= 1'b1;
        wt(4);
        st(11'h130);
        chk(low_side_brake_o, 1'b0);
        stall_detect_i <= 1'b0;
        no_motor_detect_i <= 1'b0;
        command_i <= 8'h00;
        wt(40);
        st(11'h400);
        // Masked undervoltage after reset
        rst_i <= 1'b1;
        undervoltage_mask_i <= 1'b1;
        wt(2);
        rst_i <= 1'b0;
        supply_dv_i <= 10'h045;
        wt(6);
        st(11'h400);
        report_and_stop();
    end
endmodule : ffs_top_tb_top

// ===== hw/ffs_duty_comp.sv
// Compensated duty, one phase at a time
`timescale 1ns/100ps
module ffs_duty_comp (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Carrier
    ffs_duty_if.comp dif
);
    logic [1:0] ph;
    logic [4:0] bitc;
    logic [23:0] num;
    logic [23:0] quo;
    logic [10:0] rem;
    logic [10:0] trial;
    logic fit;

    assign trial = {rem[9:0], num[23]};
    assign fit = trial >= {1'b0, dif.supply_dv};

    // Restoring divide, 24 cycles a phase; zero supply saturates
    always_ff @(posedge clock_i) begin
        dif.done <= 1'b0;
        if (rst_i) begin
            dif.busy <= 1'b0;
            dif.duty <= '0;
            ph <= 2'd0;
            bitc <= 5'd0;
            num <= '0;
            quo <= '0;
            rem <= '0;
        end else if (!dif.busy) begin
            if (dif.start) begin
                dif.busy <= 1'b1;
                ph <= 2'd0;
                bitc <= 5'd0;
                rem <= '0;
                num <= dif.v_svm[0] * dif.nominal_dv;
            end
        end else if (bitc != 5'd23) begin
            bitc <= bitc + 5'd1;
            rem <= fit ? trial - {1'b0, dif.supply_dv} : trial;
            quo <= {quo[22:0], fit};
            num <= {num[22:0], 1'b0};
        end else begin
            // Over full scale clamps to 100 percent duty
            if ({quo[22:0], fit} > {11'h000, ffs_pkg::DUTY_ONE}) begin
                dif.duty[ph] <= ffs_pkg::DUTY_ONE;
            end else begin
                dif.duty[ph] <= quo[11:0] << 1 | {12'h000, fit};
            end
            bitc <= 5'd0;
            rem <= '0;
            if (ph == 2'd2) begin
                dif.busy <= 1'b0;
                dif.done <= 1'b1;
            end else begin
                ph <= ph + 2'd1;
                num <= dif.v_svm[ph + 2'd1] * dif.nominal_dv;
            end
        end
    end
endmodule : ffs_duty_comp

// ===== hw/ffs_duty_if.sv
// Carrier for modulator and divider
`timescale 1ns/100ps
interface ffs_duty_if;
    logic [2:0][13:0] v_phase;
    logic [2:0][13:0] v_svm;
    logic [9:0] supply_dv;
    logic [9:0] nominal_dv;
    logic start;
    logic [2:0][12:0] duty;
    logic done;
    logic busy;
    modport top (output v_phase, supply_dv, nominal_dv, start, input duty, done, busy);
    modport svm (input v_phase, output v_svm);
    modport comp (input v_svm, supply_dv, nominal_dv, start, output duty, done, busy);
endinterface : ffs_duty_if

// ===== hw/ffs_pkg.sv
// Constants and types for the fault supervisor
package ffs_pkg;
    // Clock rate and time base
    localparam int CLK_MHZ = 125;
    localparam int RETRY_TOUT_US = 100000;
    localparam int RETRY_TOUT_CYC = RETRY_TOUT_US * CLK_MHZ;
    localparam int RETRY_MAX = 3;
    // Supply in 0.1 V, voltage and duty in Q12
    localparam int SUP_W = 10;
    localparam int VW = 14;
    localparam int DW = 13;
    localparam logic [12:0] DUTY_ONE = 13'h1000;
    localparam logic [13:0] SVM_MID = 14'h0800;
    // Undervoltage selector decode, in 0.1 V
    localparam logic [9:0] UV_TH_32V = 10'h140;
    localparam logic [9:0] UV_TH_25V = 10'h0fa;
    localparam logic [9:0] UV_TH_7V = 10'h046;
    localparam logic [9:0] UV_HYST = 10'h00a;
    // Thermal shutdown in degrees C
    localparam logic [7:0] TSD_TH = 8'ha5;
    localparam logic [7:0] TSD_HYST = 8'h14;
    // Observer format offsets
    localparam logic signed [6:0] LS_EXP_OFS = 7'sh15;
    localparam logic signed [6:0] RS_EXP_OFS = 7'sh0b;
    localparam logic [18:0] FREQ_DIV_BASE = 19'h00009;
    // Status flag positions
    localparam int ST_UV = 0;
    localparam int ST_OT = 1;
    localparam int ST_OV = 2;
    localparam int ST_SC = 3;
    localparam int ST_STALL = 4;
    localparam int ST_NOMOT = 5;
    localparam int ST_RETRY_END = 6;
    localparam int ST_W = 7;
    // Modes, Gray along standby, windmill, run
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_WINDMILL = 2'b01,
        MODE_RUN = 2'b11,
        MODE_FAIL = 2'b10
    } ffs_mode_type;
endpackage : ffs_pkg

// ===== hw/ffs_svm.sv
// Space-vector modulation by min-max common-mode injection
`timescale 1ns/100ps
module ffs_svm (
    ffs_duty_if.svm dif
);
    logic signed [13:0] a;
    logic signed [13:0] b;
    logic signed [13:0] c;
    logic signed [13:0] vmax;
    logic signed [13:0] vmin;
    logic signed [14:0] ofs;

    // Shift by mid of extremes so peaks use the full supply
    always_comb begin
        a = $signed(dif.v_phase[0]);
        b = $signed(dif.v_phase[1]);
        c = $signed(dif.v_phase[2]);
        vmax = (a > b) ? a : b;
        vmax = (vmax > c) ? vmax : c;
        vmin = (a < b) ? a : b;
        vmin = (vmin < c) ? vmin : c;
        ofs = ($signed({vmax[13], vmax}) + $signed({vmin[13], vmin})) >>> 1;
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ph
            logic signed [15:0] v;
            assign v = $signed({{2{dif.v_phase[g][13]}}, dif.v_phase[g]})
                - $signed({ofs[14], ofs}) + $signed({2'b00, ffs_pkg::SVM_MID});
            // Negative results clip to zero duty
            assign dif.v_svm[g] = v[15] ? 14'h0000 : v[13:0];
        end
    endgenerate
endmodule : ffs_svm

// ===== hw/ffs_top.sv
// Fault supervisor and compensated duty
//
// Behaviour
// - D-axis current reference is a setting.
// - Separate P and I gains for D and Q loops.
// - Phases use space-vector modulation.
// - Duty is phase voltage over supply times nominal.
// - Inductance exponent is fraction length plus 21.
// - Resistance exponent is fraction length plus 11.
// - Frequency divisor is nine shifted by resolution.
// - Fault pin low while a fault stands.
// - Only short faults may brake.
// - Faults maskable; stall selector zero disables stall.
// - Each fault has a status flag.
// - Supply, thermal unlatched; short latched until off-on.
// - Stall, no-motor: outputs off, retry, soft latch.
// - Undervoltage: outputs off, fail, pin, flag.
// - Supply above threshold plus hysteresis recovers.
// - Standby waits for command above on level, then windmill.
// - Selector: 0 is 32 V, 1 is 25 V, 2 is 7 V.
// - Supply and thermal checks run in every state.
// - Reprogramming in user mode during undervoltage.
// - Setting changes apply after the next reset.
// - Overtemperature: outputs off, fail, pin, flag.
// - Cooling below threshold minus hysteresis recovers.
// - After short fault, restart only below off level.
`timescale 1ns/100ps
module ffs_top #(
    parameter int RETRY_CYCLES = ffs_pkg::RETRY_TOUT_CYC,
    parameter int RETRY_MAX = ffs_pkg::RETRY_MAX
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Nonvolatile settings image
    input wire logic [1:0] undervoltage_threshold_sel_i,
    input wire logic undervoltage_mask_i,
    input wire logic overtemp_mask_i,
    input wire logic overvoltage_fault_en_i,
    input wire logic short_fault_en_i,
    input wire logic [1:0] stall_detect_select_i,
    input wire logic no_motor_detect_en_i,
    input wire logic [7:0] command_on_threshold_i,
    input wire logic [7:0] command_off_threshold_i,
    input wire logic [9:0] nominal_supply_setting_i,
    input wire logic [15:0] d_axis_current_ref_i,
    input wire logic [15:0] d_loop_prop_gain_i,
    input wire logic [15:0] d_loop_int_gain_i,
    input wire logic [15:0] q_loop_prop_gain_i,
    input wire logic [15:0] q_loop_int_gain_i,
    input wire logic [15:0] stator_inductance_setting_i,
    input wire logic [15:0] stator_resistance_setting_i,
    input wire logic [4:0] inductance_frac_length_i,
    input wire logic [4:0] resistance_frac_length_i,
    input wire logic [3:0] frequency_resolution_setting_i,
    input wire logic [15:0] observer_freq_gain_i,
    input wire logic [15:0] observer_angle_gain_i,
    // Monitors and detectors
    input wire logic [9:0] supply_dv_i,
    input wire logic logic_supply_ok_i,
    input wire logic [7:0] junction_temp_i,
    input wire logic supply_overvoltage_i,
    input wire logic short_detect_i,
    input wire logic stall_detect_i,
    input wire logic no_motor_detect_i,
    // Command and control inputs
    input wire logic [7:0] command_i,
    input wire logic windmill_done_i,
    input wire logic brake_in_n_i,
    input wire logic user_mode_i,
    input wire logic [2:0][13:0] phase_voltage_i,
    // Fault and bridge outputs
    output logic fault_out_n_o,
    output logic bridge_enable_o,
    output logic low_side_brake_o,
    output ffs_pkg::ffs_mode_type mode_o,
    output logic [6:0] fault_status_o,
    output logic nvm_program_allow_o,
    // Duty outputs
    output logic [2:0][12:0] duty_o,
    output logic duty_valid_o,
    // Control loop and observer settings
    output logic [15:0] d_ref_o,
    output logic [3:0][15:0] loop_gains_o,
    output logic [15:0] inductance_o,
    output logic [15:0] resistance_o,
    output logic signed [6:0] inductance_exp_o,
    output logic signed [6:0] resistance_exp_o,
    output logic [18:0] freq_lsb_div_o,
    output logic [1:0][15:0] observer_gains_o
);
    initial begin
        if (RETRY_CYCLES < 1 || RETRY_CYCLES > 32'h7fffffff) begin
            $error("RETRY_CYCLES out of range");
        end
        if (RETRY_MAX < 1 || RETRY_MAX > 15) begin
            $error("RETRY_MAX must be 1 to 15");
        end
    end

    // Settings captured once after reset
    logic cfg_loaded;
    logic [1:0] uv_sel;
    logic uv_mask;
    logic ot_mask;
    logic ov_en;
    logic sc_en;
    logic stall_en;
    logic nomot_en;
    logic [7:0] on_th;
    logic [7:0] off_th;
    logic [9:0] nominal;
    // Fault state
    logic uv_flag;
    logic ot_flag;
    logic ov_flag;
    logic sc_flag;
    logic stall_flag;
    logic nomot_flag;
    logic retry_end;
    logic [31:0] retry_cnt;
    logic [3:0] attempts;
    ffs_pkg::ffs_mode_type mode;
    ffs_pkg::ffs_mode_type next_mode;
    logic [9:0] uv_th;
    logic cmd_off;
    logic cmd_on;
    logic any_fault;
    logic brake_block;
    logic sw_latched;
    logic retry_tick;

    ffs_duty_if dif ();

    // Code 3 falls back to the lowest level
    function automatic logic [9:0] uv_decode(input logic [1:0] sel);
        unique case (sel)
            2'd0: uv_decode = ffs_pkg::UV_TH_32V;
            2'd1: uv_decode = ffs_pkg::UV_TH_25V;
            default: uv_decode = ffs_pkg::UV_TH_7V;
        endcase
    endfunction : uv_decode

    assign uv_th = uv_decode(uv_sel);
    assign cmd_off = command_i < off_th;
    assign cmd_on = command_i > on_th;
    assign sw_latched = stall_flag | nomot_flag;
    assign any_fault = uv_flag | ot_flag | ov_flag | sc_flag | sw_latched;
    assign brake_block = uv_flag | ot_flag | ov_flag | sw_latched;
    assign retry_tick = sw_latched && retry_cnt == 32'(RETRY_CYCLES - 1);

    // Image is taken once, so later edits wait for the next reset
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cfg_loaded <= 1'b0;
            uv_sel <= 2'd0;
            uv_mask <= 1'b1;
            ot_mask <= 1'b1;
            ov_en <= 1'b0;
            sc_en <= 1'b0;
            stall_en <= 1'b0;
            nomot_en <= 1'b0;
            on_th <= 8'hff;
            off_th <= 8'h00;
            nominal <= 10'h000;
        end else if (!cfg_loaded) begin
            cfg_loaded <= 1'b1;
            uv_sel <= undervoltage_threshold_sel_i;
            uv_mask <= undervoltage_mask_i;
            ot_mask <= overtemp_mask_i;
            ov_en <= overvoltage_fault_en_i;
            sc_en <= short_fault_en_i;
            stall_en <= stall_detect_select_i != 2'd0;
            nomot_en <= no_motor_detect_en_i;
            on_th <= command_on_threshold_i;
            off_th <= command_off_threshold_i;
            nominal <= nominal_supply_setting_i;
        end
    end

    // Loop and observer settings
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            d_ref_o <= 16'h0000;
            loop_gains_o <= '0;
            inductance_o <= 16'h0000;
            resistance_o <= 16'h0000;
            inductance_exp_o <= 7'sh00;
            resistance_exp_o <= 7'sh00;
            freq_lsb_div_o <= 19'h00000;
            observer_gains_o <= '0;
        end else if (!cfg_loaded) begin
            d_ref_o <= d_axis_current_ref_i;
            loop_gains_o <= {q_loop_int_gain_i, q_loop_prop_gain_i,
                d_loop_int_gain_i, d_loop_prop_gain_i};
            inductance_o <= stator_inductance_setting_i;
            resistance_o <= stator_resistance_setting_i;
            inductance_exp_o <= 7'($signed(inductance_frac_length_i))
                + ffs_pkg::LS_EXP_OFS;
            resistance_exp_o <= 7'($signed(resistance_frac_length_i))
                + ffs_pkg::RS_EXP_OFS;
            freq_lsb_div_o <= ffs_pkg::FREQ_DIV_BASE
                << frequency_resolution_setting_i;
            observer_gains_o <= {observer_angle_gain_i, observer_freq_gain_i};
        end
    end

    // Undervoltage with hysteresis
    always_ff @(posedge clock_i) begin
        if (rst_i || uv_mask) begin
            uv_flag <= 1'b0;
        end else if (cfg_loaded && supply_dv_i < uv_th) begin
            uv_flag <= 1'b1;
        end else if (supply_dv_i > uv_th + ffs_pkg::UV_HYST) begin
            uv_flag <= 1'b0;
        end
    end

    // Thermal shutdown with hysteresis
    always_ff @(posedge clock_i) begin
        if (rst_i || ot_mask) begin
            ot_flag <= 1'b0;
        end else if (cfg_loaded && junction_temp_i > ffs_pkg::TSD_TH) begin
            ot_flag <= 1'b1;
        end else if (junction_temp_i < ffs_pkg::TSD_TH - ffs_pkg::TSD_HYST) begin
            ot_flag <= 1'b0;
        end
    end

    // Overvoltage, never latched
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ov_flag <= 1'b0;
        end else begin
            ov_flag <= ov_en && cfg_loaded && supply_overvoltage_i;
        end
    end

    // Short fault holds until the command drops below off; set wins
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sc_flag <= 1'b0;
        end else if (sc_en && cfg_loaded && short_detect_i) begin
            sc_flag <= 1'b1;
        end else if (cmd_off) begin
            sc_flag <= 1'b0;
        end
    end

    // Stall and no-motor count only in run
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            stall_flag <= 1'b0;
            nomot_flag <= 1'b0;
        end else begin
            if (stall_en && mode == ffs_pkg::MODE_RUN && stall_detect_i) begin
                stall_flag <= 1'b1;
            end else if (retry_tick && !stall_detect_i && !no_motor_detect_i) begin
                stall_flag <= 1'b0;
            end else if (retry_end && cmd_off) begin
                stall_flag <= 1'b0;
            end
            if (nomot_en && mode == ffs_pkg::MODE_RUN && no_motor_detect_i) begin
                nomot_flag <= 1'b1;
            end else if (retry_tick && !stall_detect_i && !no_motor_detect_i) begin
                nomot_flag <= 1'b0;
            end else if (retry_end && cmd_off) begin
                nomot_flag <= 1'b0;
            end
        end
    end

    // Retry timeout; after the last attempt only an off command clears
    always_ff @(posedge clock_i) begin
        if (rst_i || !sw_latched) begin
            retry_cnt <= 32'd0;
            attempts <= 4'd0;
            retry_end <= 1'b0;
        end else if (retry_end) begin
            retry_cnt <= 32'd0;
        end else if (retry_tick) begin
            retry_cnt <= 32'd0;
            attempts <= attempts + 4'd1;
            retry_end <= attempts == 4'(RETRY_MAX - 1);
        end else begin
            retry_cnt <= retry_cnt + 32'd1;
        end
    end

    // Mode sequence
    always_comb begin
        next_mode = mode;
        unique case (mode)
            ffs_pkg::MODE_STANDBY: begin
                if (cmd_on) begin
                    next_mode = ffs_pkg::MODE_WINDMILL;
                end
            end
            ffs_pkg::MODE_WINDMILL: begin
                if (cmd_off) begin
                    next_mode = ffs_pkg::MODE_STANDBY;
                end else if (windmill_done_i) begin
                    next_mode = ffs_pkg::MODE_RUN;
                end
            end
            ffs_pkg::MODE_RUN: begin
                if (cmd_off) begin
                    next_mode = ffs_pkg::MODE_STANDBY;
                end
            end
            ffs_pkg::MODE_FAIL: begin
                next_mode = ffs_pkg::MODE_STANDBY;
            end
        endcase
        if (any_fault) begin
            next_mode = ffs_pkg::MODE_FAIL;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i || !cfg_loaded) begin
            mode <= ffs_pkg::MODE_STANDBY;
        end else begin
            mode <= next_mode;
        end
    end

    // Pin outputs, registered
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            fault_out_n_o <= 1'b1;
            bridge_enable_o <= 1'b0;
            low_side_brake_o <= 1'b0;
            mode_o <= ffs_pkg::MODE_STANDBY;
            fault_status_o <= '0;
            nvm_program_allow_o <= 1'b0;
        end else begin
            fault_out_n_o <= !any_fault;
            bridge_enable_o <= !any_fault && (next_mode == ffs_pkg::MODE_WINDMILL
                || next_mode == ffs_pkg::MODE_RUN);
            // No brake while a non-brakeable fault stands
            low_side_brake_o <= !brake_in_n_i && !brake_block;
            mode_o <= next_mode;
            fault_status_o[ffs_pkg::ST_UV] <= uv_flag;
            fault_status_o[ffs_pkg::ST_OT] <= ot_flag;
            fault_status_o[ffs_pkg::ST_OV] <= ov_flag;
            fault_status_o[ffs_pkg::ST_SC] <= sc_flag;
            fault_status_o[ffs_pkg::ST_STALL] <= stall_flag;
            fault_status_o[ffs_pkg::ST_NOMOT] <= nomot_flag;
            fault_status_o[ffs_pkg::ST_RETRY_END] <= retry_end;
            nvm_program_allow_o <= user_mode_i && uv_flag && logic_supply_ok_i;
        end
    end

    // Divider restarts whenever idle
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dif.v_phase <= '0;
            dif.supply_dv <= 10'h000;
            dif.start <= 1'b0;
        end else begin
            dif.start <= cfg_loaded && !dif.busy && !dif.start;
            if (!dif.busy) begin
                dif.v_phase <= phase_voltage_i;
                dif.supply_dv <= supply_dv_i;
            end
        end
    end
    assign dif.nominal_dv = nominal;

    // Duty held at zero while the bridge is off
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            duty_o <= '0;
            duty_valid_o <= 1'b0;
        end else begin
            duty_valid_o <= dif.done;
            if (!bridge_enable_o) begin
                duty_o <= '0;
            end else if (dif.done) begin
                duty_o <= dif.duty;
            end
        end
    end

    ffs_svm u_svm (
        .dif(dif.svm)
    );

    ffs_duty_comp u_duty (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .dif(dif.comp)
    );
endmodule : ffs_top
